// >>> test/wol_detector_asserts.sv
// Port-level checks of the wake-on-LAN detector, bound to its top module.
// Assumes one clock domain and the two-cycle APB access of the design.
`timescale 1ns/1ps
`default_nettype none
module wol_detector_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Receive and power side
  input wire logic rx_last_i,
  input wire logic rx_ok_i,
  input wire logic power_event_output_o,
  input wire logic irq_o,
  input wire logic rx_normal_enable_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Setup cycle followed by the first access cycle
  sequence s_acc_start;
    psel_i && !penable_i ##1 psel_i && penable_i;
  endsequence

  // Answer comes one edge after the first access edge, for one cycle only
  AST_PREADY_TIMING: assert property (s_acc_start |=> pready_o ##1 !pready_o)
    else $error("pready timing wrong");
  AST_READY_IN_ACCESS: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access");
  AST_PSLVERR: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error answer malformed");
  AST_PRDATA_HOLD: assert property (!penable_i |=> $stable(prdata_o))
    else $error("read data moved outside access");
  // Mode changes only follow a register write
  AST_RXNORM: assert property ($changed(rx_normal_enable_o) |-> $past(pready_o && pwrite_i, 1) || $past(pready_o && pwrite_i, 2))
    else $error("receive enable moved without write");
  AST_PIN_RISE: assert property ($rose(power_event_output_o) |-> $past(rx_last_i && rx_ok_i, 2) || $past(pready_o, 2) || $past(pready_o, 1))
    else $error("event pin rose without cause");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(rx_last_i && rx_ok_i, 2) || $past(pready_o, 2) || $past(pready_o, 1))
    else $error("irq rose without cause");
  AST_PIN_FALL: assert property ($fell(power_event_output_o) |-> $past(pready_o, 2) || $past(pready_o, 1))
    else $error("event pin fell without write");
endmodule : wol_detector_asserts
`default_nettype wire

bind wol_detector wol_detector_asserts wol_detector_asserts_inst (.clock_i(clock_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rx_last_i(rx_last_i), .rx_ok_i(rx_ok_i), .power_event_output_o(power_event_output_o),
  .irq_o(irq_o), .rx_normal_enable_o(rx_normal_enable_o));

// >>> test/wol_detector_tb_top.sv
// Self-checking bench for the wake-on-LAN detector: APB host tasks and
// hand-written scenarios. Assumes the receive model of wol_rx_model.
`timescale 1ns/1ps
`default_nettype none
module wol_detector_tb_top;
  logic clock_i, reset_i, psel, penable, pwrite, sleep, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, pin, irq, rxn; // Design outputs
  logic rx_valid, rx_last, rx_ok;
  logic [7:0] rx_data;
  logic [31:0] w [0:39]; // Filter image
  logic [15:0] exp_crc;
  int fails, samples_checked;
  localparam logic [47:0] STN = 48'h5544_3322_1102; // Byte 0 in [7:0]

  wol_detector wol_detector_inst (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_ok_i(rx_ok),
    .sleep_i(sleep), .power_event_output_o(pin), .irq_o(irq), .rx_normal_enable_o(rxn));
  wol_rx_model wol_rx_model_inst (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_last_o(rx_last), .rx_ok_o(rx_ok));

  // 50 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One APB transfer; read data lands in rd, error flag in err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst();
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask : rst

  // Destination first, then a counting payload
  task automatic fill(input logic [47:0] da);
    for (int i = 0; i < 128; i++) wol_rx_model_inst.frame[i] = (i < 6) ? da[8*i+:8] : 8'(8'h20 + i);
  endtask : fill

  task automatic station();
    apb(1'b1, wol_pkg::ADDR_STN_LOWER, STN[31:0]);
    apb(1'b1, wol_pkg::ADDR_STN_UPPER, {16'h0, STN[47:32]});
  endtask : station

  // Reflected CRC-16 step over one byte, lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h0, b};
    for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ wol_pkg::CRC_POLY_REFL) : (c >> 1);
    return c;
  endfunction : crc16

  task automatic t_regs();
    rst();
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h40, 32'hffff_ffff); // Unmapped place is refused
    chk({31'h0, err}, 32'h1);
    apb(1'b0, wol_pkg::ADDR_PWR_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_port();
    rst();
    for (int i = 0; i < 5; i++) apb(1'b1, wol_pkg::ADDR_FILT_PORT, 32'hdead_0000);
    rst(); // Index must restart at word zero
    for (int i = 0; i < 40; i++) w[i] = 32'h5ac3_0000 + i;
    for (int i = 0; i < 40; i++) apb(1'b1, wol_pkg::ADDR_FILT_PORT, w[i]);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, wol_pkg::ADDR_FILT_PORT, 32'h0);
      chk(rd, w[i]);
    end
    apb(1'b0, wol_pkg::ADDR_FILT_PORT, 32'h0);
    chk(rd, w[0]);
    $display("test port done");
  endtask : t_port

  task automatic t_exact();
    rst();
    station();
    apb(1'b1, wol_pkg::ADDR_PWR_CTRL, 32'h5);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h1);
    repeat (3) @(posedge clock_i);
    chk({31'h0, rxn}, 32'h0);
    fill(STN ^ 48'h1); // One bit off the station address
    wol_rx_model_inst.send(20, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h1);
    fill(STN);
    wol_rx_model_inst.send(20, 2, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h21);
    apb(1'b0, wol_pkg::ADDR_PWR_CTRL, 32'h0);
    chk(rd, 32'h7);
    chk({31'h0, pin}, 32'h1);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h20);
    repeat (3) @(posedge clock_i);
    chk({31'h0, rxn}, 32'h1);
    $display("test exact done");
  endtask : t_exact

  task automatic t_bcast();
    rst();
    apb(1'b1, wol_pkg::ADDR_PWR_CTRL, 32'h9);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h2);
    fill(wol_pkg::BCAST_ADDR);
    wol_rx_model_inst.send(16, 0, 1'b0); // Bad frame raises nothing
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h2);
    wol_rx_model_inst.send(16, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h42);
    chk({30'h0, irq, pin}, 32'h2);
    chk({31'h0, rxn}, 32'h0);
    $display("test bcast done");
  endtask : t_bcast

  task automatic t_defer();
    rst();
    station();
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h11);
    fill(STN);
    wol_rx_model_inst.send(16, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h11);
    sleep <= 1'b1;
    wol_rx_model_inst.send(16, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h31);
    sleep <= 1'b0;
    $display("test defer done");
  endtask : t_defer

  // Filter 3 checks bytes 14, 16 and 46; filter 0 stays disabled
  task automatic t_pattern();
    apb(1'b0, wol_pkg::ADDR_FILT_PORT, 32'h0); // Leaves the index off zero; reset must undo it
    rst();
    station();
    fill(STN);
    for (int i = 0; i < 40; i++) w[i] = 32'h0;
    w[12] = 32'h5;
    w[13] = 32'h1;
    w[32] = 32'h0100_0000;
    w[34] = 32'h0e00_0000; // Offset 14, above the address bytes
    exp_crc = crc16(crc16(crc16(wol_pkg::CRC_INIT, 8'h2e), 8'h30), 8'h4e);
    w[37] = {exp_crc, 16'h0};
    for (int i = 0; i < 40; i++) apb(1'b1, wol_pkg::ADDR_FILT_PORT, w[i]); // Loaded before enabling
    apb(1'b1, wol_pkg::ADDR_PWR_CTRL, 32'h4);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h4);
    wol_rx_model_inst.send(64, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h84);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h84); // Clears the flag, keeps patterns on
    chk({31'h0, pin}, 32'h0);
    wol_rx_model_inst.frame[15] = 8'hff; // Unmasked byte changes nothing
    wol_rx_model_inst.send(64, 1, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h84);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h84);
    wol_rx_model_inst.frame[46] = 8'h4f; // Byte under mask bit 32
    wol_rx_model_inst.send(64, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h4);
    // Same filter, now asking for a group destination instead of the station
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h0); // Patterns off while the store changes
    w[32] = 32'h0900_0000;
    for (int i = 0; i < 40; i++) apb(1'b1, wol_pkg::ADDR_FILT_PORT, w[i]);
    apb(1'b1, wol_pkg::ADDR_WAKE_CTRL, 32'h4);
    fill(STN); // Station destination has no group bit
    wol_rx_model_inst.send(64, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h4);
    fill(STN | 48'h1); // Group bit set, payload unchanged
    wol_rx_model_inst.send(64, 0, 1'b1);
    apb(1'b0, wol_pkg::ADDR_WAKE_CTRL, 32'h0);
    chk(rd, 32'h84);
    $display("test pattern done");
  endtask : t_pattern

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    {reset_i, psel, penable, pwrite, sleep} = 5'h10;
    paddr = 8'h0;
    pwdata = 32'h0;
    fails = 0;
    samples_checked = 0;
    t_regs();
    t_port();
    t_exact();
    t_bcast();
    t_defer();
    t_pattern();
    test_done();
  end

  // Watchdog, far beyond the roughly 1500 cycles the tests need
  initial begin
    repeat (30000) @(posedge clock_i);
    fails++;
    test_done();
  end
endmodule : wol_detector_tb_top
`default_nettype wire

// >>> test/wol_rx_model.sv
// Receive path model: plays a stored frame into the detector, byte by byte.
// Assumes the bench fills frame[] and calls send from its own process.
`timescale 1ns/1ps
`default_nettype none
module wol_rx_model (
  // Clock
  input wire logic clock_i,
  // Byte stream towards the detector
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic rx_ok_o
);
  logic [7:0] frame [0:127]; // Bytes to play, destination first

  // Idle levels at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5a;
    rx_last_o = 1'b0;
    rx_ok_o = 1'b0;
  end

  // Plays n bytes; gap idle cycles per byte model a slow path
  task automatic send(input int n, input int gap, input logic ok);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= frame[i];
      rx_last_o <= (i == n - 1);
      rx_ok_o <= ok;
      repeat (gap) begin
        @(posedge clock_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~frame[i]; // Idle data never shows the old byte
      end
    end
    @(posedge clock_i);
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~frame[n-1];
  endtask : send
endmodule : wol_rx_model
`default_nettype wire

// >>> verilog/wol_detector.sv
// Receive-side wake-on-LAN detector: exact address, broadcast and eight
// masked CRC-16 pattern filters, reported through a power control register.
// Assumes receive bytes arrive on clock_i from the MAC receive path, with
// rx_last_i and rx_ok_i marking the final byte of each frame.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module wol_detector #(
  parameter int NUM_FILT = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Receive bytes from the MAC
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_ok_i,
  // Power management side
  input wire logic sleep_i,
  output logic power_event_output_o,
  output logic irq_o,
  output logic rx_normal_enable_o
);

  localparam int IW = 6;
  localparam logic [IW-1:0] LAST_IDX = IW'(wol_pkg::FILT_WORDS - 1);

  if (NUM_FILT != wol_pkg::NUM_FILTERS) begin : g_chk
    $error("wol_detector: filter store holds exactly eight filters");
  end

  // CRC-16 over one byte, lsb first, reflected polynomial
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      if (r[0] ^ d[b]) begin
        r = (r >> 1) ^ wol_pkg::CRC_POLY_REFL;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_byte

  // Register state
  logic [7:0] wctrl_q; // wake_control_status_reg
  logic [3:0] pctrl_q; // power_mgmt_control_reg
  logic [31:0] stn_lo_q; // station_addr_lower, first byte in bits 7:0
  logic [15:0] stn_hi_q; // station_addr_upper
  logic [IW-1:0] fidx_q; // Filter port index
  logic [31:0] fmem_rd; // Filter word at the index, registered
  logic [wol_pkg::FILT_WORDS*32-1:0] fwords; // Whole filter store

  // APB handshake: one wait state so read data can come from a flop
  logic access;
  logic done;
  assign access = psel_i & penable_i;
  assign done = access & pready_o;

  logic hit_ctrl, hit_pwr, hit_lo, hit_hi, hit_port;
  assign hit_ctrl = (paddr_i == wol_pkg::ADDR_WAKE_CTRL);
  assign hit_pwr = (paddr_i == wol_pkg::ADDR_PWR_CTRL);
  assign hit_lo = (paddr_i == wol_pkg::ADDR_STN_LOWER);
  assign hit_hi = (paddr_i == wol_pkg::ADDR_STN_UPPER);
  assign hit_port = (paddr_i == wol_pkg::ADDR_FILT_PORT);

  // Ready strobe, high on the second access cycle only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= access & ~pready_o;
    end
  end

  // Read mux and error, loaded while ready rises
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (access & ~pready_o) begin
      pslverr_o <= ~(hit_ctrl | hit_pwr | hit_lo | hit_hi | hit_port);
      if (pwrite_i) begin
        prdata_o <= 32'h0000_0000;
      end else if (hit_ctrl) begin
        prdata_o <= {24'h00_0000, wctrl_q};
      end else if (hit_pwr) begin
        prdata_o <= {28'h000_0000, pctrl_q};
      end else if (hit_lo) begin
        prdata_o <= stn_lo_q;
      end else if (hit_hi) begin
        prdata_o <= {16'h0000, stn_hi_q};
      end else if (hit_port) begin
        prdata_o <= fmem_rd;
      end else begin
        prdata_o <= 32'h0000_0000;
      end
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // Filter port index steps on every completed port access and wraps
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fidx_q <= '0;
    end else if (done & hit_port) begin
      if (fidx_q == LAST_IDX) begin
        fidx_q <= '0;
      end else begin
        fidx_q <= fidx_q + IW'(1);
      end
    end
  end

  wol_filter_mem #(
    .WORDS(wol_pkg::FILT_WORDS),
    .IW(IW)
  ) u_mem (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .wr_en_i(done & hit_port & pwrite_i),
    .wr_idx_i(fidx_q),
    .wr_data_i(pwdata_i),
    .rd_idx_i(fidx_q),
    .rd_data_o(fmem_rd),
    .words_o(fwords)
  );

  // Station address registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      stn_lo_q <= 32'h0000_0000;
      stn_hi_q <= 16'h0000;
    end else if (done & pwrite_i) begin
      if (hit_lo) begin
        stn_lo_q <= pwdata_i;
      end else if (hit_hi) begin
        stn_hi_q <= pwdata_i[15:0];
      end
    end
  end

  // Frame tracking: byte count and captured destination address
  logic [10:0] bcnt_q; // Byte index within the frame, saturating
  logic [47:0] da_q; // Destination, first wire byte in bits 7:0
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      bcnt_q <= 11'h000;
      da_q <= 48'h0000_0000_0000;
    end else if (rx_valid_i) begin
      if (bcnt_q < 11'(wol_pkg::DA_BYTES)) begin
        da_q[bcnt_q[2:0]*8 +: 8] <= rx_data_i;
      end
      if (rx_last_i) begin
        bcnt_q <= 11'h000;
      end else if (bcnt_q != 11'h7ff) begin
        bcnt_q <= bcnt_q + 11'h001;
      end
    end
  end

  // Detection runs unless told to wait for the power-down state
  logic active;
  logic frame_end;
  logic [47:0] stn_addr;
  logic stn_match;
  assign active = ~wctrl_q[wol_pkg::WC_DEFER] | sleep_i;
  assign frame_end = rx_valid_i & rx_last_i & rx_ok_i;
  assign stn_addr = {stn_hi_q, stn_lo_q};
  assign stn_match = (da_q == stn_addr);

  // Per-filter masked CRC; every filter runs in parallel on the same bytes
  logic [NUM_FILT-1:0] filt_hit;
  for (genvar i = 0; i < NUM_FILT; i++) begin : g_filt
    logic [wol_pkg::MASK_BITS-1:0] mask;
    logic [3:0] cmd;
    logic [7:0] ofs;
    logic [15:0] exp_crc;
    logic [11:0] rel;
    logic take;
    logic [15:0] crc_q;
    logic [15:0] crc_now;
    logic addr_ok;
    // Word 4i is mask bits 31:0, lsb = first byte after the offset
    assign mask = fwords[i*wol_pkg::MASK_WORDS*32 +: wol_pkg::MASK_BITS];
    assign cmd = fwords[(wol_pkg::CMD_BASE + i/4)*32 + (i%4)*8 +: 4];
    assign ofs = fwords[(wol_pkg::OFS_BASE + i/4)*32 + (i%4)*8 +: 8];
    assign exp_crc = fwords[(wol_pkg::CRC_BASE + i/2)*32 + (i%2)*16 +: 16];
    assign rel = {1'b0, bcnt_q} - {4'h0, ofs};
    // Offsets of eleven or less would feed address bytes; host keeps them above
    assign take = cmd[wol_pkg::CMD_ENABLE] & (bcnt_q >= {3'h0, ofs})
                  & (rel < 12'(wol_pkg::MASK_BITS)) & mask[rel[6:0]];
    assign crc_now = take ? crc_byte(crc_q, rx_data_i) : crc_q;
    // Unicast filters need the station address; multicast ones a group bit
    assign addr_ok = cmd[wol_pkg::CMD_MULTICAST] ? da_q[0] : stn_match;
    assign filt_hit[i] = cmd[wol_pkg::CMD_ENABLE] & addr_ok
                         & (crc_now == exp_crc);

    // Running CRC, restarted at the end of every frame
    always_ff @(posedge clock_i) begin
      if (reset_i) begin
        crc_q <= wol_pkg::CRC_INIT;
      end else if (rx_valid_i) begin
        if (rx_last_i) begin
          crc_q <= wol_pkg::CRC_INIT;
        end else begin
          crc_q <= crc_now;
        end
      end
    end
  end

  // Detection events, one-cycle pulses at a good frame's end
  logic exact_ev, bcast_ev, pat_ev, any_ev;
  assign exact_ev = frame_end & active & wctrl_q[wol_pkg::WC_EXACT_EN] & stn_match;
  assign bcast_ev = frame_end & active & wctrl_q[wol_pkg::WC_BCAST_EN]
                    & (da_q == wol_pkg::BCAST_ADDR);
  assign pat_ev = frame_end & active & wctrl_q[wol_pkg::WC_PATTERN_EN] & (|filt_hit);
  assign any_ev = exact_ev | bcast_ev | pat_ev;

  // Wake control register: enables written, seen flags write-one-to-clear
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wctrl_q <= 8'h00;
    end else begin
      if (done & pwrite_i & hit_ctrl) begin
        wctrl_q[wol_pkg::WC_DEFER:0] <= pwdata_i[wol_pkg::WC_DEFER:0];
        wctrl_q[7:5] <= wctrl_q[7:5] & ~pwdata_i[7:5];
      end
      // Hardware set wins over a clear in the same cycle
      if (exact_ev) begin
        wctrl_q[wol_pkg::WC_EXACT_SEEN] <= 1'b1;
      end
      if (bcast_ev) begin
        wctrl_q[wol_pkg::WC_BCAST_SEEN] <= 1'b1;
      end
      if (pat_ev) begin
        wctrl_q[wol_pkg::WC_PATTERN_SEEN] <= 1'b1;
      end
    end
  end

  // Power control register with the sticky wake status
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pctrl_q <= 4'h0;
    end else begin
      if (done & pwrite_i & hit_pwr) begin
        pctrl_q[wol_pkg::PM_GLOBAL_EN] <= pwdata_i[wol_pkg::PM_GLOBAL_EN];
        pctrl_q[wol_pkg::PM_EVENT_PIN_EN] <= pwdata_i[wol_pkg::PM_EVENT_PIN_EN];
        pctrl_q[wol_pkg::PM_IRQ_EN] <= pwdata_i[wol_pkg::PM_IRQ_EN];
        if (pwdata_i[wol_pkg::PM_WAKE_STATUS]) begin
          pctrl_q[wol_pkg::PM_WAKE_STATUS] <= 1'b0;
        end
      end
      if (any_ev) begin
        pctrl_q[wol_pkg::PM_WAKE_STATUS] <= 1'b1;
      end
    end
  end

  // Output pins: status only reaches them through the global enable
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      power_event_output_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      power_event_output_o <= pctrl_q[wol_pkg::PM_WAKE_STATUS] & pctrl_q[wol_pkg::PM_GLOBAL_EN]
                              & pctrl_q[wol_pkg::PM_EVENT_PIN_EN];
      irq_o <= pctrl_q[wol_pkg::PM_WAKE_STATUS] & pctrl_q[wol_pkg::PM_GLOBAL_EN]
               & pctrl_q[wol_pkg::PM_IRQ_EN];
    end
  end

  // Normal reception is held off while exact, broadcast or pattern detection is on
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_normal_enable_o <= 1'b1;
    end else begin
      rx_normal_enable_o <= ~(wctrl_q[wol_pkg::WC_EXACT_EN] | wctrl_q[wol_pkg::WC_BCAST_EN]
                              | wctrl_q[wol_pkg::WC_PATTERN_EN]);
    end
  end

endmodule : wol_detector
`default_nettype wire

// >>> verilog/wol_filter_mem.sv
// Word store for the wake-up frame filters with a registered read port
// and a flat view of every word for the match logic.
// Assumes writes and reads are issued by one owner on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wol_filter_mem #(
  parameter int WORDS = 40,
  parameter int IW = 6
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [IW-1:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  // Read port, data one cycle after the index
  input wire logic [IW-1:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  // Every word, for the matchers
  output logic [WORDS*32-1:0] words_o
);

  logic [31:0] mem_q [WORDS]; // Storage words

  if (WORDS > (1 << IW)) begin : g_chk
    $error("wol_filter_mem: index too narrow");
  end

  // Storage cleared by reset so a half-loaded set never matches garbage
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      for (int k = 0; k < WORDS; k++) begin
        mem_q[k] <= 32'h0000_0000;
      end
    end else if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_data_i;
    end
  end

  // Registered read data
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_data_o <= 32'h0000_0000;
    end else begin
      rd_data_o <= mem_q[rd_idx_i];
    end
  end

  // Flat view
  always_comb begin
    for (int k = 0; k < WORDS; k++) begin
      words_o[k*32 +: 32] = mem_q[k];
    end
  end

endmodule : wol_filter_mem
`default_nettype wire

// >>> verilog/wol_pkg.sv
// Shared constants for the wake-on-LAN detector: register map, field
// positions, filter store layout and CRC settings.
// Assumes a 32-bit APB register bus with one aligned word per register.
package wol_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_WAKE_CTRL = 8'h00; // wake_control_status_reg
  localparam logic [7:0] ADDR_PWR_CTRL = 8'h04; // power_mgmt_control_reg
  localparam logic [7:0] ADDR_STN_LOWER = 8'h08; // station_addr_lower
  localparam logic [7:0] ADDR_STN_UPPER = 8'h0c; // station_addr_upper
  localparam logic [7:0] ADDR_FILT_PORT = 8'h10; // wake_filter_port

  // Field positions in wake_control_status_reg
  localparam int WC_EXACT_EN = 0;
  localparam int WC_BCAST_EN = 1;
  localparam int WC_PATTERN_EN = 2;
  localparam int WC_MAGIC_EN = 3;
  localparam int WC_DEFER = 4;
  localparam int WC_EXACT_SEEN = 5;
  localparam int WC_BCAST_SEEN = 6;
  localparam int WC_PATTERN_SEEN = 7;

  // Field positions in power_mgmt_control_reg
  localparam int PM_GLOBAL_EN = 0;
  localparam int PM_WAKE_STATUS = 1;
  localparam int PM_EVENT_PIN_EN = 2;
  localparam int PM_IRQ_EN = 3;

  // Filter store layout, in words
  localparam int NUM_FILTERS = 8;
  localparam int MASK_WORDS = 4;
  localparam int FILT_WORDS = 40;
  localparam int CMD_BASE = 32;
  localparam int OFS_BASE = 34;
  localparam int CRC_BASE = 36;
  localparam int CMD_ENABLE = 0;
  localparam int CMD_MULTICAST = 3;

  // Frame bookkeeping
  localparam int DA_BYTES = 6;
  localparam int MASK_BITS = 128;
  localparam logic [47:0] BCAST_ADDR = 48'hffff_ffff_ffff;

  // CRC-16, reflected polynomial, all-ones start
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;

endpackage : wol_pkg
